// ==== common/flash_host_cfg.svh ====
`ifndef FLASH_HOST_CFG_SVH
`define FLASH_HOST_CFG_SVH

// ----------------------------------------------------------------
// Bus geometry
// ----------------------------------------------------------------
`define ADDR_W         17
`define DATA_W         8
`define SECT_W         3

// ----------------------------------------------------------------
// Timing, clock period and derived cycle counts
// ----------------------------------------------------------------
`define CLK_PERIOD_NS  10
// Chip-select access time, nanoseconds (least wait, rounds up)
`define T_CE_NS        90
`define T_CE_CYC       ((`T_CE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// Output-enable access time, nanoseconds
`define T_OE_NS        35
`define T_OE_CYC       ((`T_OE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// Write pulse low width, nanoseconds
`define T_WP_NS        45
`define T_WP_CYC       ((`T_WP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// Write pulse high width / recovery, nanoseconds
`define T_WPH_NS       20
`define T_WPH_CYC      ((`T_WPH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// Minimum hardware reset pulse, nanoseconds
`define T_RP_NS        500
`define T_RP_CYC       ((`T_RP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// Counter width for all waits
`define CNT_W          8
`define CNT_ONE        8'h01
`define CNT_ZERO       8'h00

// ----------------------------------------------------------------
// Sector numbers
// ----------------------------------------------------------------
`define SECTOR_ZERO    3'h0
`define SECTOR_ONE     3'h1
`define SECTOR_TWO     3'h2
`define SECTOR_THREE   3'h3
`define SECTOR_FOUR    3'h4
`define SECTOR_FIVE    3'h5
`define SECTOR_SIX     3'h6

`endif

// ==== common/flash_host_pkg.sv ====
package flash_host_pkg;

  // Host sequencer states
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_RESET  = 3'b001,
    ST_RD_CE  = 3'b010,
    ST_RD_HLD = 3'b011,
    ST_WR_LO  = 3'b100,
    ST_WR_HI  = 3'b101
  } host_state_t;

endpackage

// ==== design/sector_decode.sv ====
`timescale 1ns/100ps
`default_nettype none

`include "flash_host_cfg.svh"

// Maps address bits 16..12 to a sector number for either boot variant
module sector_decode
  import flash_host_pkg::*;
(
  input  wire logic [4:0]         upper_in,  // Address bits 16..12
  input  wire logic               top_in,    // High selects top-boot map
  output logic      [`SECT_W-1:0] sector_out // Decoded sector number
);

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------

  // Top and bottom tables, smallest set of upper bits per sector
  always_comb
  begin
    sector_out = `SECTOR_ZERO;
    if (top_in)
    begin
      if (!upper_in[4])
        sector_out = upper_in[3] ? `SECTOR_ONE : `SECTOR_ZERO;
      else if (!upper_in[3])
        sector_out = `SECTOR_TWO;
      else if (!upper_in[2])
        sector_out = `SECTOR_THREE;
      else if (upper_in[1])
        sector_out = `SECTOR_SIX;
      else
        sector_out = upper_in[0] ? `SECTOR_FIVE : `SECTOR_FOUR;
    end
    else
    begin
      if (upper_in[4])
        sector_out = upper_in[3] ? `SECTOR_SIX : `SECTOR_FIVE;
      else if (upper_in[3])
        sector_out = `SECTOR_FOUR;
      else if (upper_in[2])
        sector_out = `SECTOR_THREE;
      else if (!upper_in[1])
        sector_out = `SECTOR_ZERO;
      else
        sector_out = upper_in[0] ? `SECTOR_TWO : `SECTOR_ONE;
    end
  end

endmodule

`default_nettype wire

// ==== design/flash_host.sv ====
`timescale 1ns/100ps
`default_nettype none

`include "flash_host_cfg.svh"

module flash_host
  import flash_host_pkg::*;
(
  input  wire logic               clk_in,         // System clock, 100 MHz
  input  wire logic               rst_n_in,       // Async reset, active low
  input  wire logic               top_boot_in,    // Sector map variant
  input  wire logic               rd_req_in,      // Read request level
  input  wire logic               wr_req_in,      // Command write request
  input  wire logic               rst_req_in,     // Hardware reset request
  input  wire logic [`ADDR_W-1:0] addr_in,        // Request byte address
  input  wire logic [`DATA_W-1:0] wdata_in,       // Command write data
  output logic                    req_ready_out,  // Idle, request taken
  output logic                    done_out,       // Request completed
  output logic      [`DATA_W-1:0] rdata_out,      // Captured read data
  output logic      [`SECT_W-1:0] sector_out,     // Sector of last address
  output logic                    reissue_out,    // Reset cut a write
  output logic                    ce_n_out,       // Chip select, low
  output logic                    oe_n_out,       // Output enable, low
  output logic                    we_n_out,       // Write enable, low
  output logic                    reset_n_out,    // Device reset, low
  output logic      [`ADDR_W-1:0] addr_out,       // Device address pins
  output logic      [`DATA_W-1:0] dq_out,         // Data pins, driven
  output logic                    dq_oe_out,      // High while driving dq
  input  wire logic [`DATA_W-1:0] dq_in           // Data pins, sampled
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  host_state_t        state_q, state_d;     // Sequencer state
  logic [`CNT_W-1:0]  cnt_q, cnt_d;         // Wait counter
  logic [`ADDR_W-1:0] addr_q, addr_d;       // Address held on pins
  logic [`DATA_W-1:0] wdat_q, wdat_d;       // Data held on pins
  logic [`DATA_W-1:0] rdat_q, rdat_d;       // Read capture
  logic               done_q, done_d;       // Completion pulse
  logic               wrseen_q, wrseen_d;   // Write since last reset
  logic               reiss_q, reiss_d;     // Reissue advice flag
  logic               ce_n_q, ce_n_d;       // Select pin
  logic               oe_n_q, oe_n_d;       // Output enable pin
  logic               we_n_q, we_n_d;       // Write enable pin
  logic               rs_n_q, rs_n_d;       // Reset pin
  logic               dqoe_q, dqoe_d;       // Drive enable
  logic [`SECT_W-1:0] sect_q, sect_d;       // Registered sector number

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------

  // One sequencer for read, write and reset cycles
  always_comb
  begin
    state_d  = state_q;
    cnt_d    = cnt_q;
    addr_d   = addr_q;
    wdat_d   = wdat_q;
    rdat_d   = rdat_q;
    done_d   = 1'b0;
    wrseen_d = wrseen_q;
    reiss_d  = reiss_q;
    ce_n_d   = ce_n_q;
    oe_n_d   = oe_n_q;
    we_n_d   = we_n_q;
    rs_n_d   = rs_n_q;
    dqoe_d   = dqoe_q;
    case (state_q)
      ST_IDLE:
      begin
        // Standby between cycles, all strobes high
        ce_n_d = 1'b1;
        oe_n_d = 1'b1;
        we_n_d = 1'b1;
        dqoe_d = 1'b0;
        if (rst_req_in)
        begin
          // hold reset low for the pulse time
          rs_n_d  = 1'b0;
          cnt_d   = `CNT_W'(`T_RP_CYC);
          state_d = ST_RESET;
        end
        else if (wr_req_in)
        begin
          // select and write low, output high
          addr_d   = addr_in;
          wdat_d   = wdata_in;
          ce_n_d   = 1'b0;
          we_n_d   = 1'b0;
          dqoe_d   = 1'b1;
          wrseen_d = 1'b1;
          reiss_d  = 1'b0;
          cnt_d    = `CNT_W'(`T_WP_CYC);
          state_d  = ST_WR_LO;
        end
        else if (rd_req_in)
        begin
          // select and output enable low, write high
          addr_d  = addr_in;
          ce_n_d  = 1'b0;
          oe_n_d  = 1'b0;
          cnt_d   = `CNT_W'(`T_CE_CYC);
          state_d = ST_RD_CE;
        end
      end
      ST_RESET:
      begin
        // Count the reset pulse down, then release
        if (cnt_q == `CNT_ONE)
        begin
          // flag any write sequence the reset cut
          reiss_d  = wrseen_q;
          wrseen_d = 1'b0;
          rs_n_d   = 1'b1;
          done_d   = 1'b1;
          state_d  = ST_IDLE;
        end
        else
          cnt_d = cnt_q - `CNT_ONE;
      end
      ST_RD_CE:
      begin
        // wait full select access after standby
        if (cnt_q == `CNT_ONE)
        begin
          rdat_d  = dq_in;
          done_d  = 1'b1;
          ce_n_d  = 1'b1;
          oe_n_d  = 1'b1;
          cnt_d   = `CNT_W'(`T_WPH_CYC);
          state_d = ST_RD_HLD;
        end
        else
          cnt_d = cnt_q - `CNT_ONE;
      end
      ST_RD_HLD, ST_WR_HI:
      begin
        // Recovery with strobes high before next cycle
        if (cnt_q == `CNT_ONE)
          state_d = ST_IDLE;
        else
          cnt_d = cnt_q - `CNT_ONE;
      end
      ST_WR_LO:
      begin
        // rising write edge latches the data
        if (cnt_q == `CNT_ONE)
        begin
          we_n_d  = 1'b1;
          ce_n_d  = 1'b1;
          done_d  = 1'b1;
          cnt_d   = `CNT_W'(`T_WPH_CYC);
          state_d = ST_WR_HI;
        end
        else
          cnt_d = cnt_q - `CNT_ONE;
      end
      default:
      begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------

  // Pin and state registers, all strobes inactive in reset
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      state_q  <= ST_IDLE;
      cnt_q    <= `CNT_ZERO;
      addr_q   <= '0;
      wdat_q   <= '0;
      rdat_q   <= '0;
      done_q   <= 1'b0;
      wrseen_q <= 1'b0;
      reiss_q  <= 1'b0;
      ce_n_q   <= 1'b1;
      oe_n_q   <= 1'b1;
      we_n_q   <= 1'b1;
      rs_n_q   <= 1'b1;
      dqoe_q   <= 1'b0;
      sect_q   <= `SECTOR_ZERO;
    end
    else
    begin
      state_q  <= state_d;
      cnt_q    <= cnt_d;
      addr_q   <= addr_d;
      wdat_q   <= wdat_d;
      rdat_q   <= rdat_d;
      done_q   <= done_d;
      wrseen_q <= wrseen_d;
      reiss_q  <= reiss_d;
      ce_n_q   <= ce_n_d;
      oe_n_q   <= oe_n_d;
      we_n_q   <= we_n_d;
      rs_n_q   <= rs_n_d;
      dqoe_q   <= dqoe_d;
      sect_q   <= sect_d;
    end
  end

  // ----------------------------------------------------------------
  // Sector decode and outputs
  // ----------------------------------------------------------------

  // report sector of the held address
  sector_decode u_sector_decode (
    .upper_in   (addr_q[`ADDR_W-1:`ADDR_W-5]),
    .top_in     (top_boot_in),
    .sector_out (sect_d)
  );

  // Sector number leaves through a flip-flop like the other data outputs
  assign sector_out    = sect_q;

  assign req_ready_out = (state_q == ST_IDLE) && !done_q;
  assign done_out      = done_q;
  assign rdata_out     = rdat_q;
  assign reissue_out   = reiss_q;
  assign ce_n_out      = ce_n_q;
  assign oe_n_out      = oe_n_q;
  assign we_n_out      = we_n_q;
  assign reset_n_out   = rs_n_q;
  assign addr_out      = addr_q;
  assign dq_out        = wdat_q;
  assign dq_oe_out     = dqoe_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------

  property p_read_strobes;
    @(posedge clk_in) disable iff (!rst_n_in)
      (!oe_n_out) |-> (!ce_n_out && we_n_out && reset_n_out && !dq_oe_out);
  endproperty
  a_read_strobes: assert property (p_read_strobes) else $error("bad read strobes");

  property p_write_strobes;
    @(posedge clk_in) disable iff (!rst_n_in)
      (!we_n_out) |-> (!ce_n_out && oe_n_out && dq_oe_out);
  endproperty
  a_write_strobes: assert property (p_write_strobes) else $error("bad write strobes");

  property p_read_wait;
    @(posedge clk_in) disable iff (!rst_n_in)
      $fell(oe_n_out) |-> !oe_n_out [*8] ##1 !oe_n_out ##1 (oe_n_out && done_out);
  endproperty
  a_read_wait: assert property (p_read_wait) else $error("read ended early");

  property p_reset_len;
    @(posedge clk_in) disable iff (!rst_n_in)
      $fell(reset_n_out) |-> !reset_n_out [*8];
  endproperty
  a_reset_len: assert property (p_reset_len) else $error("reset pulse short");

  property p_reset_quiet;
    @(posedge clk_in) disable iff (!rst_n_in)
      !reset_n_out |-> (ce_n_out && oe_n_out && we_n_out);
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("access during reset");

  property p_we_high_read;
    @(posedge clk_in) disable iff (!rst_n_in)
      (state_q == ST_RD_CE) |-> we_n_out;
  endproperty
  a_we_high_read: assert property (p_we_high_read) else $error("write low in read");

  property p_write_width;
    @(posedge clk_in) disable iff (!rst_n_in)
      $fell(we_n_out) |-> !we_n_out [*5] ##1 (we_n_out && done_out);
  endproperty
  a_write_width: assert property (p_write_width) else $error("write pulse wrong");

  property p_addr_stable;
    @(posedge clk_in) disable iff (!rst_n_in)
      (!ce_n_out && !$past(ce_n_out)) |-> $stable(addr_out);
  endproperty
  a_addr_stable: assert property (p_addr_stable) else $error("address moved");

endmodule

`default_nettype wire

// ==== testbench/flash_device_model.sv ====
`timescale 1ns/100ps
`default_nettype none

`include "flash_host_cfg.svh"

// Behavioural byte-wide flash seen from its pins
module flash_device_model
#(
  parameter logic [7:0] ID_CODE = 8'h5A,  // Identifier, arbitrary value
  parameter int         ACC_NS  = 80,     // Select to valid data
  parameter int         BUSY_NS = 300     // Embedded program length
)
(
  input  wire logic               ce_n_in,    // Chip select, low
  input  wire logic               oe_n_in,    // Output enable, low
  input  wire logic               we_n_in,    // Write enable, low
  input  wire logic               reset_n_in, // Reset, low
  input  wire logic [`ADDR_W-1:0] addr_in,    // Address pins
  input  wire logic [`DATA_W-1:0] dq_in,      // Resolved data wire
  output logic      [`DATA_W-1:0] dq_out,     // Data driven out
  output logic                    dq_oe_out,  // High while driving
  output logic      [7:0]         err_out     // Pin protocol slips
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {M_ARRAY, M_AUTO, M_PROG} mode_t;
  logic [7:0]  mem [0:131071];  // Array contents
  mode_t       mode_q;          // Read mode of the state machine
  logic [16:0] lat_a;           // Latched write address
  logic [16:0] prog_a;          // Address being programmed
  logic [7:0]  prog_d;          // Byte being programmed
  logic [7:0]  old_d;           // Contents before programming
  logic [7:0]  rd_val;          // Byte a read would return
  logic        wr_open;         // Write strobes both low
  logic        busy_q;          // Embedded program running
  logic        valid_q;         // Access time has run out

  // Power-up contents and mode
  // array read at power-up
  initial
  begin
    for (int k = 0; k < 131072; k++) mem[k] = k[7:0] ^ k[15:8] ^ {7'h00, k[16]};
    mode_q = M_ARRAY;
    wr_open = 1'b0;
    busy_q = 1'b0;
    valid_q = 1'b0;
    err_out = 8'h00;
  end

  // Address latch at the later falling strobe
  // command latch
  always @(negedge ce_n_in or negedge we_n_in)
    if (!ce_n_in && !we_n_in && oe_n_in && reset_n_in)
    begin
      lat_a = addr_in;
      wr_open = 1'b1;
    end

  // Data latch at the earlier rising strobe, command decode
  // latch and decode
  always @(posedge ce_n_in or posedge we_n_in)
    if (wr_open)
    begin
      wr_open = 1'b0;
      if (mode_q == M_PROG)
      begin
        old_d = mem[lat_a];
        prog_a = lat_a;
        prog_d = dq_in;
        mem[lat_a] = dq_in;
        mode_q = M_ARRAY;
        busy_q = 1'b1;
        // runs on whatever the select does
        busy_q <= #(BUSY_NS) 1'b0;
      end
      else if (dq_in == 8'h90) mode_q = M_AUTO;
      else if (dq_in == 8'hA0) mode_q = M_PROG;
      else mode_q = M_ARRAY;
    end

  // Hardware reset aborts and returns to array read
  // abort to array
  always @(negedge reset_n_in)
  begin
    if (busy_q) mem[prog_a] = old_d;
    busy_q = 1'b0;
    mode_q = M_ARRAY;
    wr_open = 1'b0;
  end

  // Access time after select
  // data late after select
  always @(negedge ce_n_in)
  begin
    valid_q = 1'b0;
    valid_q <= #(ACC_NS) 1'b1;
  end

  // Read source by mode
  // identifier and status
  always @*
    if (busy_q) rd_val = {~prog_d[7], 7'h00};
    else if (mode_q == M_AUTO) rd_val = ID_CODE;
    else rd_val = mem[addr_in];

  // Output drive, wrong data before access time
  // drive only when read
  assign dq_oe_out = !ce_n_in && !oe_n_in && we_n_in && reset_n_in;
  assign dq_out = valid_q ? rd_val : ~rd_val;

  // Write strobe during an enabled output
  // write high in reads
  always @(negedge we_n_in)
    if (!oe_n_in) err_out = err_out + 8'h01;
endmodule

`default_nettype wire

// ==== testbench/flash_host_tb_top.sv ====
`timescale 1ns/100ps
`default_nettype none

`include "flash_host_cfg.svh"

module flash_host_tb_top;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  localparam logic [7:0] ID = 8'h5A;  // Identifier, arbitrary value
  logic              clk, rst_n, top_boot, rd_req, wr_req, rst_req;
  logic              ready, done, reissue, ce_n, oe_n, we_n, reset_n;
  logic              dq_oe_h, dq_oe_m, wrote, reis_exp;
  logic [16:0]       addr, a_pin, ra, p;
  logic [7:0]        wdata, rdata, dq_h, dq_m, bus, bus_last, last_rd, d, dev_err;
  logic [2:0]        sector;
  logic [11:0]       got, e, m;
  logic [11:0]       exp_q[$], msk_q[$];  // Expected notes and masks
  logic [7:0]        mirror[logic [16:0]]; // Bytes programmed so far
  int                bad_count, checks, n;
  logic [16:0]       bnd [16] = '{17'h00000, 17'h01FFF, 17'h02000, 17'h02FFF,
    17'h03000, 17'h04000, 17'h07FFF, 17'h08000, 17'h0FFFF, 17'h10000, 17'h18000,
    17'h1BFFF, 17'h1C000, 17'h1D000, 17'h1E000, 17'h1FFFF};

  // ----------------------------------------------------------------
  // Instances and data wire
  // ----------------------------------------------------------------
  flash_host flash_host_inst (.clk_in(clk), .rst_n_in(rst_n), .top_boot_in(top_boot),
    .rd_req_in(rd_req), .wr_req_in(wr_req), .rst_req_in(rst_req), .addr_in(addr),
    .wdata_in(wdata), .req_ready_out(ready), .done_out(done), .rdata_out(rdata),
    .sector_out(sector), .reissue_out(reissue), .ce_n_out(ce_n), .oe_n_out(oe_n),
    .we_n_out(we_n), .reset_n_out(reset_n), .addr_out(a_pin), .dq_out(dq_h),
    .dq_oe_out(dq_oe_h), .dq_in(bus));
  flash_device_model #(.ID_CODE(ID)) flash_device_model_inst (.ce_n_in(ce_n),
    .oe_n_in(oe_n), .we_n_in(we_n), .reset_n_in(reset_n), .addr_in(a_pin), .dq_in(bus),
    .dq_out(dq_m), .dq_oe_out(dq_oe_m), .err_out(dev_err));
  // Undriven wire shows a changing pattern
  assign bus = dq_oe_m ? dq_m : (dq_oe_h ? dq_h : ~bus_last);
  always @(posedge clk) bus_last <= bus;
  always #5 clk = ~clk;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic fail(input logic [11:0] ev, input logic [11:0] gv);
    bad_count++;
    $display("[FAIL] t=%0t exp=%h got=%h", $time, ev, gv);
  endtask

  task automatic close_out;
    $display("checks=%0d bad_count=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  function automatic logic [7:0] rd_exp(input logic [16:0] a);
    return mirror.exists(a) ? mirror[a] : a[7:0] ^ a[15:8] ^ {7'h00, a[16]};
  endfunction

  // Sector of an address for either map
  function automatic logic [2:0] sect(input logic top, input logic [16:0] a);
    if (top) return (a[16:15] != 2'b11) ? {1'b0, a[16:15]} :
      !a[14] ? 3'h3 : !a[13] ? {2'b10, a[12]} : 3'h6;
    return (a[16:15] != 2'b00) ? 3'h3 + {1'b0, a[16:15]} :
      a[14] ? 3'h3 : !a[13] ? 3'h0 : 3'h1 + {2'b00, a[12]};
  endfunction

  // One request; kind 0 read, 1 write, 2 reset, 3 read and write
  task automatic op(input int kind, input logic [16:0] a, input logic [7:0] dv,
                    input logic [7:0] ev, input logic top);
    n = 0;
    while (ready !== 1'b1 && n < 200)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n == 200) fail(12'h000, 12'h000);
    if (n == 200) close_out();
    top_boot = top;
    addr = a;
    wdata = dv;
    rd_req = (kind == 0 || kind == 3);
    wr_req = (kind == 1 || kind == 3);
    rst_req = (kind == 2);
    if (kind == 0) last_rd = ev;
    if (kind == 1 || kind == 3) reis_exp = 1'b0;
    if (kind == 1 || kind == 3) wrote = 1'b1;
    if (kind == 2) reis_exp = wrote;
    if (kind == 2) wrote = 1'b0;
    exp_q.push_back({reis_exp, sect(top, a), last_rd});
    msk_q.push_back(kind == 2 ? 12'h8FF : 12'hFFF);
    // Held past the take, so a busy host must refuse it
    repeat (3) @(posedge clk);
    #1;
    rd_req = 1'b0;
    wr_req = 1'b0;
    rst_req = 1'b0;
  endtask

  // ----------------------------------------------------------------
  // Result watcher
  // ----------------------------------------------------------------
  always @(negedge clk)
    if (done === 1'b1)
    begin
      got[10:0] = {sector, rdata};
      @(negedge clk);
      got[11] = reissue;
      checks++;
      if (exp_q.size() == 0) fail(12'h000, got);
      else
      begin
        e = exp_q.pop_front();
        m = msk_q.pop_front();
        if ((got & m) !== (e & m)) fail(e, got);
      end
    end

  // Both parties on the wire at once
  always @(posedge clk)
    if (dq_oe_m === 1'b1 && dq_oe_h === 1'b1) fail(12'h000, 12'h001);

  initial
  begin
    #200000;
    fail(12'h000, 12'h000);
    close_out();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    {clk, rst_n, top_boot, rd_req, wr_req, rst_req, wrote, reis_exp} = 8'h00;
    {addr, wdata, last_rd, bus_last} = 41'h0;
    bad_count = 0;
    checks = 0;
    void'($urandom(7));
    repeat (3) @(posedge clk);
    #1;
    rst_n = 1'b1;
    for (int i = 0; i < 32; i++)
      op(0, bnd[i[3:0]], 8'h00, rd_exp(bnd[i[3:0]]), i[4]);
    for (int i = 0; i < 8; i++)
    begin
      ra = 17'($urandom);
      op(0, ra, 8'h00, rd_exp(ra), 1'($urandom));
    end
    p = 17'($urandom);
    d = 8'($urandom);
    op(1, p, 8'hA0, 8'h00, 1'b1);
    op(1, p, d, 8'h00, 1'b1);
    mirror[p] = d;
    op(0, p, 8'h00, {~d[7], 7'h00}, 1'b1);
    repeat (40) @(posedge clk);
    #1;
    op(0, p, 8'h00, d, 1'b0);
    op(3, ra, 8'h90, 8'h00, 1'b0);
    op(0, ra, 8'h00, ID, 1'b0);
    op(1, ra, 8'h55, 8'h00, 1'b0);
    op(0, ra, 8'h00, rd_exp(ra), 1'b0);
    op(1, 17'h0, 8'h90, 8'h00, 1'b1);
    op(2, 17'h0, 8'h00, 8'h00, 1'b1);
    op(0, ra, 8'h00, rd_exp(ra), 1'b1);
    op(1, ra, 8'hA0, 8'h00, 1'b0);
    op(1, ra, ~d, 8'h00, 1'b0);
    op(2, 17'h0, 8'h00, 8'h00, 1'b0);
    op(0, ra, 8'h00, rd_exp(ra), 1'b0);
    n = 0;
    while (exp_q.size() != 0 && n < 100)
    begin
      @(posedge clk);
      n++;
    end
    checks++;
    if (exp_q.size() != 0) fail(12'h000, 12'(exp_q.size()));
    checks++;
    if (dev_err !== 8'h00) fail(12'h000, {4'h0, dev_err});
    close_out();
  end
endmodule

`default_nettype wire
